// ### afp_pkg.sv
// constants and types shared by the conversion scheduler and fault guard
package afp_pkg;
  // register port addresses
  localparam logic [7:0] AFP_SFR_INDEX    = 8'h96;
  localparam logic [7:0] AFP_SFR_WINDOW   = 8'h97;
  // motor register space indices
  localparam logic [7:0] AFP_MR_ADC_CFG   = 8'h1F;
  localparam logic [7:0] AFP_MR_HALL_STAT = 8'h1A;
  localparam logic [7:0] AFP_MR_CUR_FIRST = 8'h20;
  localparam logic [7:0] AFP_MR_CUR_LAST  = 8'h25;
  localparam logic [7:0] AFP_MR_FAULT     = 8'h27;
  localparam logic [7:0] AFP_MR_VOL_FIRST = 8'h28;
  localparam logic [7:0] AFP_MR_VOL_LAST  = 8'h2D;
  localparam logic [7:0] AFP_MR_IN_CFG    = 8'h2E;
  localparam logic [7:0] AFP_MR_AUX0_LO   = 8'h30;
  localparam logic [7:0] AFP_MR_AUX0_HI   = 8'h31;
  localparam logic [7:0] AFP_MR_AUX3_LO   = 8'h36;
  localparam logic [7:0] AFP_MR_AUX3_HI   = 8'h37;
  localparam logic [7:0] AFP_MR_POS_LIM   = 8'h44;
  localparam logic [7:0] AFP_MR_NEG_LIM   = 8'h45;
  localparam logic [7:0] AFP_MR_SHORT_LIM = 8'h46;
  // reset values
  localparam logic [7:0] AFP_RST_ADC_CFG  = 8'h00;
  localparam logic [7:0] AFP_RST_IN_CFG   = 8'h07;
  localparam logic [7:0] AFP_RST_POS_LIM  = 8'hFF;
  localparam logic [7:0] AFP_RST_NEG_LIM  = 8'h00;
  localparam logic [7:0] AFP_RST_SHORT    = 8'hFF;
  // adc config fields
  localparam int AFP_CFG_TSRC_LSB = 0;
  localparam int AFP_CFG_GAIN_LSB = 2;
  localparam int AFP_CFG_MANUAL   = 4;
  localparam int AFP_CFG_BUSY     = 5;
  // channels
  localparam int AFP_NCH          = 8;
  localparam int AFP_RES_W        = 10;
  localparam logic [2:0] AFP_CH_VOL0 = 3'h3;
  localparam logic [2:0] AFP_CH_AUX0 = 3'h6;
  localparam logic [2:0] AFP_CH_AUX3 = 3'h7;
  localparam logic [7:0] AFP_MASK_CUR = 8'h07;
  localparam logic [7:0] AFP_MASK_VOL = 8'h38;
  localparam logic [7:0] AFP_MASK_AUX = 8'hC0;
  // timing
  localparam int AFP_CLK_PERIOD_NS = 10;
  localparam int AFP_SAMPLE_NS     = 500;
  localparam int AFP_SAMPLE_CYC    = (AFP_SAMPLE_NS + AFP_CLK_PERIOD_NS - 1) / AFP_CLK_PERIOD_NS;
  localparam logic [3:0] AFP_VOL_DIV_MASK = 4'h3;
  localparam logic [3:0] AFP_AUX_DIV_MASK = 4'hF;

  typedef enum logic [1:0] {
    AFP_TRIG_PEAK   = 2'h0,
    AFP_TRIG_VALLEY = 2'h1,
    AFP_TRIG_TIMER0 = 2'h2,
    AFP_TRIG_MANUAL = 2'h3
  } afp_trig_e;

  typedef enum logic [4:0] {
    AFP_IDLE    = 5'b00001,
    AFP_SAMPLE  = 5'b00010,
    AFP_CONVERT = 5'b00100,
    AFP_STORE   = 5'b01000,
    AFP_DONE    = 5'b10000
  } afp_state_e;

  typedef struct packed {
    logic pwm_off;
    logic oc_low;
    logic oc_high;
    logic hall_err;
    logic slow_hall;
    logic short_c;
    logic short_b;
    logic short_a;
  } afp_fault_s;

  typedef struct packed {
    logic [2:0] sel;
    logic       hold;
    logic       start;
    logic [1:0] gain;
  } afp_conv_s;
endpackage

// ### afp_result_mem.sv
// conversion result store, one word per channel, registered read
`timescale 1ns/100ps
module afp_result_mem (
  input  wire logic       core_clk,  // system clock
  input  wire logic       rst,       // async reset, active high
  input  wire logic       wr_en,     // write strobe
  input  wire logic [2:0] wr_addr,   // channel written
  input  wire logic [9:0] wr_data,   // result written
  input  wire logic [2:0] rd_addr,   // channel read
  output logic      [9:0] rd_data    // registered read data
);
  logic [9:0] mem [0:7];
  logic [9:0] rd_next;

  always_comb begin
    rd_next = mem[rd_addr];
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 10'h000;
    end else begin
      rd_data <= rd_next;
    end
  end
endmodule

// ### afp_core.sv
// adc conversion scheduler and current / hall fault protection
`timescale 1ns/100ps
module afp_core (
  input  wire logic             core_clk,        // system clock
  input  wire logic             rst,             // async reset, active high
  input  wire logic [7:0]       sfr_addr,        // mcu special register address
  input  wire logic             sfr_wr,          // write strobe
  input  wire logic             sfr_rd,          // read strobe
  input  wire logic [7:0]       sfr_wdata,       // write data
  output logic      [7:0]       sfr_rdata,       // read data, one cycle after strobe
  input  wire logic             carrier_peak,    // pwm carrier peak pulse
  input  wire logic             carrier_valley,  // pwm carrier valley pulse
  input  wire logic             timer0_ovf,      // timer 0 overflow pulse
  input  wire logic             pwm_cycle_start, // new pwm cycle pulse
  input  wire logic [2:0]       hall_state,      // hall sensor inputs
  input  wire logic             hall_period_ovf, // hall period counter overflow pulse
  output afp_pkg::afp_conv_s    conv_ctl,        // channel select, hold, start, gain
  input  wire logic             conv_done,       // converter finished pulse
  input  wire logic [9:0]       conv_data,       // converter result
  output logic      [2:0]       current_sense_en,// current-sensing mode per phase input
  output logic                  pwm_enable,      // pwm outputs allowed
  output logic                  adc_ready_irq,   // conversion set complete pulse
  output logic                  fault_interrupt  // shared fault interrupt level
);
  import afp_pkg::*;

  // register port state
  logic [7:0] index_reg, index_next;
  logic [7:0] adc_cfg_reg, adc_cfg_next;
  logic [7:0] in_cfg_reg, in_cfg_next;
  logic [7:0] pos_lim_reg, pos_lim_next;
  logic [7:0] neg_lim_reg, neg_lim_next;
  logic [7:0] short_lim_reg, short_lim_next;
  logic [7:0] rdata_next;
  logic       manual_start;
  logic       win_wr;
  logic       win_rd;
  // scheduler state
  afp_state_e state_reg, state_next;
  logic [7:0] pend_reg, pend_next;
  logic [2:0] ch_reg, ch_next;
  logic [3:0] trig_cnt_reg, trig_cnt_next;
  logic [9:0] cyc_reg, cyc_next;
  logic [9:0] res_reg, res_next;
  logic       ready_next;
  logic       trig;
  logic [2:0] first_ch;
  logic       store_en;
  // fault state
  afp_fault_s flt_reg, flt_next;
  logic [6:0] clr_mask;
  logic       hall_bad;
  logic       cur_new;
  logic       above_pos, below_neg, above_short;
  logic       oc_trip_reg, oc_trip_next;
  // result store read side
  logic [2:0] rd_ch;
  logic [9:0] rd_res;
  logic       res_hit;

  assign win_wr = sfr_wr && (sfr_addr == AFP_SFR_WINDOW);
  assign win_rd = sfr_rd && (sfr_addr == AFP_SFR_WINDOW);
  assign manual_start = win_wr && (index_reg == AFP_MR_ADC_CFG) && sfr_wdata[AFP_CFG_MANUAL];
  assign clr_mask = (win_wr && (index_reg == AFP_MR_FAULT)) ? sfr_wdata[6:0] : 7'h00;

  // register port: index and motor register writes
  always_comb begin
    index_next     = index_reg;
    adc_cfg_next   = adc_cfg_reg;
    in_cfg_next    = in_cfg_reg;
    pos_lim_next   = pos_lim_reg;
    neg_lim_next   = neg_lim_reg;
    short_lim_next = short_lim_reg;
    if (sfr_wr && (sfr_addr == AFP_SFR_INDEX)) begin
      index_next = sfr_wdata;
    end
    if (win_wr) begin
      if (index_reg == AFP_MR_ADC_CFG) begin
        adc_cfg_next = {4'h0, sfr_wdata[3:0]};
      end else if (index_reg == AFP_MR_IN_CFG) begin
        in_cfg_next = {5'h00, sfr_wdata[2:0]};
      end else if (index_reg == AFP_MR_POS_LIM) begin
        pos_lim_next = sfr_wdata;
      end else if (index_reg == AFP_MR_NEG_LIM) begin
        neg_lim_next = sfr_wdata;
      end else if (index_reg == AFP_MR_SHORT_LIM) begin
        short_lim_next = sfr_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      index_reg     <= 8'h00;
      adc_cfg_reg   <= AFP_RST_ADC_CFG;
      in_cfg_reg    <= AFP_RST_IN_CFG;
      pos_lim_reg   <= AFP_RST_POS_LIM;
      neg_lim_reg   <= AFP_RST_NEG_LIM;
      short_lim_reg <= AFP_RST_SHORT;
    end else begin
      index_reg     <= index_next;
      adc_cfg_reg   <= adc_cfg_next;
      in_cfg_reg    <= in_cfg_next;
      pos_lim_reg   <= pos_lim_next;
      neg_lim_reg   <= neg_lim_next;
      short_lim_reg <= short_lim_next;
    end
  end

  assign current_sense_en = in_cfg_reg[2:0];

  // map the index onto a stored result channel
  always_comb begin
    rd_ch   = 3'h0;
    res_hit = 1'b1;
    if (index_reg >= AFP_MR_CUR_FIRST && index_reg <= AFP_MR_CUR_LAST) begin
      rd_ch = 3'((index_reg - AFP_MR_CUR_FIRST) >> 1);
    end else if (index_reg >= AFP_MR_VOL_FIRST && index_reg <= AFP_MR_VOL_LAST) begin
      rd_ch = AFP_CH_VOL0 + 3'((index_reg - AFP_MR_VOL_FIRST) >> 1);
    end else if (index_reg == AFP_MR_AUX0_LO || index_reg == AFP_MR_AUX0_HI) begin
      rd_ch = AFP_CH_AUX0;
    end else if (index_reg == AFP_MR_AUX3_LO || index_reg == AFP_MR_AUX3_HI) begin
      rd_ch = AFP_CH_AUX3;
    end else begin
      res_hit = 1'b0;
    end
  end

  afp_result_mem u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (store_en),
    .wr_addr  (ch_reg),
    .wr_data  (res_reg),
    .rd_addr  (rd_ch),
    .rd_data  (rd_res)
  );

  // read data for both ports; unmapped indices read zero
  always_comb begin
    rdata_next = sfr_rdata;
    if (sfr_rd && (sfr_addr == AFP_SFR_INDEX)) begin
      rdata_next = index_reg;
    end else if (win_rd) begin
      if (res_hit) begin
        rdata_next = index_reg[0] ? {6'h00, rd_res[9:8]} : rd_res[7:0];
      end else if (index_reg == AFP_MR_ADC_CFG) begin
        rdata_next = adc_cfg_reg;
        rdata_next[AFP_CFG_BUSY] = (state_reg != AFP_IDLE);
      end else if (index_reg == AFP_MR_HALL_STAT) begin
        rdata_next = {5'h00, hall_state};
      end else if (index_reg == AFP_MR_FAULT) begin
        rdata_next = flt_reg;
      end else if (index_reg == AFP_MR_IN_CFG) begin
        rdata_next = in_cfg_reg;
      end else if (index_reg == AFP_MR_POS_LIM) begin
        rdata_next = pos_lim_reg;
      end else if (index_reg == AFP_MR_NEG_LIM) begin
        rdata_next = neg_lim_reg;
      end else if (index_reg == AFP_MR_SHORT_LIM) begin
        rdata_next = short_lim_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_next;
    end
  end

  // trigger source select
  always_comb begin
    case (afp_trig_e'(adc_cfg_reg[AFP_CFG_TSRC_LSB +: 2]))
      AFP_TRIG_PEAK:   trig = carrier_peak;
      AFP_TRIG_VALLEY: trig = carrier_valley;
      AFP_TRIG_TIMER0: trig = timer0_ovf;
      default:         trig = manual_start;
    endcase
  end

  // lowest pending channel goes first
  always_comb begin
    first_ch = 3'h0;
    for (int i = AFP_NCH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        first_ch = 3'(i);
      end
    end
  end

  assign store_en = (state_reg == AFP_STORE);

  // conversion scheduler; triggers while busy are ignored
  always_comb begin
    state_next    = state_reg;
    pend_next     = pend_reg;
    ch_next       = ch_reg;
    trig_cnt_next = trig_cnt_reg;
    cyc_next      = cyc_reg;
    res_next      = res_reg;
    ready_next    = 1'b0;
    case (state_reg)
      AFP_IDLE: begin
        if (trig) begin
          pend_next = AFP_MASK_CUR;
          if ((trig_cnt_reg & AFP_VOL_DIV_MASK) == 4'h0) begin
            pend_next = pend_next | AFP_MASK_VOL;
          end
          if ((trig_cnt_reg & AFP_AUX_DIV_MASK) == 4'h0) begin
            pend_next = pend_next | AFP_MASK_AUX;
          end
          trig_cnt_next = trig_cnt_reg + 4'h1;
          ch_next       = 3'h0;
          cyc_next      = 10'h000;
          state_next    = AFP_SAMPLE;
        end
      end
      AFP_SAMPLE: begin
        cyc_next = cyc_reg + 10'h001;
        if (cyc_reg == 10'(AFP_SAMPLE_CYC - 1)) begin
          state_next = AFP_CONVERT;
        end
      end
      AFP_CONVERT: begin
        if (conv_done) begin
          // converter data is only valid with its strobe, keep it for the store
          res_next   = conv_data;
          state_next = AFP_STORE;
        end
      end
      AFP_STORE: begin
        pend_next = pend_reg & ~(8'h01 << ch_reg);
        cyc_next  = 10'h000;
        if ((pend_reg & ~(8'h01 << ch_reg)) == 8'h00) begin
          state_next = AFP_DONE;
        end else begin
          state_next = AFP_SAMPLE;
        end
      end
      AFP_DONE: begin
        ready_next = 1'b1;
        state_next = AFP_IDLE;
      end
      default: begin
        state_next = AFP_IDLE;
      end
    endcase
    if (state_reg == AFP_SAMPLE && cyc_reg == 10'h000) begin
      ch_next = first_ch;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= AFP_IDLE;
      pend_reg      <= 8'h00;
      ch_reg        <= 3'h0;
      trig_cnt_reg  <= 4'h0;
      cyc_reg       <= 10'h000;
      res_reg       <= 10'h000;
      adc_ready_irq <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pend_reg      <= pend_next;
      ch_reg        <= ch_next;
      trig_cnt_reg  <= trig_cnt_next;
      cyc_reg       <= cyc_next;
      res_reg       <= res_next;
      adc_ready_irq <= ready_next;
    end
  end

  always_comb begin
    conv_ctl.sel   = ch_reg;
    conv_ctl.hold  = (state_reg == AFP_SAMPLE);
    conv_ctl.start = (state_reg == AFP_SAMPLE) && (cyc_reg == 10'(AFP_SAMPLE_CYC - 1));
    conv_ctl.gain  = adc_cfg_reg[AFP_CFG_GAIN_LSB +: 2];
  end

  // threshold checks on each fresh phase-current result
  assign cur_new     = store_en && (ch_reg < AFP_CH_VOL0);
  assign above_pos   = cur_new && (res_reg[9:2] > pos_lim_reg);
  assign below_neg   = cur_new && (res_reg[9:2] < neg_lim_reg);
  assign above_short = cur_new && (res_reg[9:2] > short_lim_reg);
  assign hall_bad    = (hall_state == 3'b111) || (hall_state == 3'b000);

  // sticky fault flags except pwm_off; a new event wins over a software clear
  always_comb begin
    flt_next = flt_reg;
    flt_next.short_a   = (flt_reg.short_a & ~clr_mask[0]) | (above_short && ch_reg == 3'h0);
    flt_next.short_b   = (flt_reg.short_b & ~clr_mask[1]) | (above_short && ch_reg == 3'h1);
    flt_next.short_c   = (flt_reg.short_c & ~clr_mask[2]) | (above_short && ch_reg == 3'h2);
    flt_next.slow_hall = (flt_reg.slow_hall & ~clr_mask[3]) | hall_period_ovf;
    flt_next.hall_err  = (flt_reg.hall_err & ~clr_mask[4]) | hall_bad;
    flt_next.oc_high   = (flt_reg.oc_high & ~clr_mask[5]) | above_pos;
    flt_next.oc_low    = (flt_reg.oc_low & ~clr_mask[6]) | below_neg;
    // over-current holds only until the next pwm cycle; a new trip wins
    oc_trip_next = (oc_trip_reg & ~pwm_cycle_start) | above_pos | below_neg;
    flt_next.pwm_off = ~(~oc_trip_next & ~above_pos & ~below_neg & ~flt_next.hall_err);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flt_reg     <= '0;
      oc_trip_reg <= 1'b0;
    end else begin
      flt_reg     <= flt_next;
      oc_trip_reg <= oc_trip_next;
    end
  end

  // over-current cuts pwm in the same cycle as detection
  assign pwm_enable = ~oc_trip_reg & ~above_pos & ~below_neg & ~flt_reg.hall_err;
  // short and slow-hall only interrupt, pwm stays on for them
  assign fault_interrupt = flt_reg.short_a | flt_reg.short_b | flt_reg.short_c
                         | flt_reg.slow_hall | flt_reg.hall_err;
endmodule

// ### afp_core_props.sv
// concurrent checks on the scheduler and fault guard ports
`timescale 1ns/100ps
module afp_core_props
  import afp_pkg::*;
(
  input wire logic       core_clk,         // system clock
  input wire logic       rst,              // reset
  input wire logic [7:0] sfr_addr,         // sfr address
  input wire logic       sfr_wr,           // write strobe
  input wire logic       sfr_rd,           // read strobe
  input wire logic [7:0] sfr_rdata,        // read data
  input wire logic [2:0] hall_state,       // hall inputs
  input wire logic       hall_period_ovf,  // slow hall pulse
  input wire afp_conv_s  conv_ctl,         // converter control
  input wire logic [2:0] current_sense_en, // sense config
  input wire logic       pwm_enable,       // pwm allowed
  input wire logic       adc_ready_irq,    // set complete
  input wire logic       fault_interrupt   // fault level
);
  logic win_wr;
  assign win_wr = sfr_wr && (sfr_addr == AFP_SFR_WINDOW);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_hall_bad;
    hall_state == 3'h0 || hall_state == 3'h7;
  endsequence
  sequence s_sample_run;
    conv_ctl.hold && $past(conv_ctl.hold, 49) && !$past(conv_ctl.hold, 50);
  endsequence
  property p_hall_pwm;
    s_hall_bad |=> !pwm_enable;
  endproperty
  property p_hall_irq;
    s_hall_bad |-> ##[1:2] fault_interrupt;
  endproperty
  property p_pwm_hold;
    s_hall_bad ##1 !win_wr |=> !pwm_enable;
  endproperty
  property p_slow_irq;
    hall_period_ovf |-> ##[1:2] fault_interrupt;
  endproperty
  property p_sticky;
    fault_interrupt && !win_wr && !$past(win_wr) |=> fault_interrupt;
  endproperty
  property p_irq_pulse;
    adc_ready_irq |=> !adc_ready_irq;
  endproperty
  property p_start_hold;
    conv_ctl.start |-> s_sample_run ##1 !conv_ctl.start;
  endproperty
  property p_rd_other;
    sfr_rd && sfr_addr != AFP_SFR_INDEX && sfr_addr != AFP_SFR_WINDOW |=> $stable(sfr_rdata);
  endproperty
  property p_sense_rst;
    $past(rst) |-> current_sense_en == 3'h7;
  endproperty
  a_hall_pwm: assert property (p_hall_pwm) else $error("hall error left pwm on");
  a_hall_irq: assert property (p_hall_irq) else $error("hall error no interrupt");
  a_pwm_hold: assert property (p_pwm_hold) else $error("pwm resumed uncleared");
  a_slow_irq: assert property (p_slow_irq) else $error("slow hall no interrupt");
  a_sticky: assert property (p_sticky) else $error("fault dropped uncleared");
  a_irq_pulse: assert property (p_irq_pulse) else $error("ready not one cycle");
  a_start_hold: assert property (p_start_hold) else $error("sample time wrong");
  a_rd_other: assert property (p_rd_other) else $error("foreign read changed data");
  a_sense_rst: assert property (p_sense_rst) else $error("sense config not default");
endmodule
bind afp_core afp_core_props afp_core_props_i (.core_clk, .rst, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_rdata, .hall_state, .hall_period_ovf, .conv_ctl, .current_sense_en,
  .pwm_enable, .adc_ready_irq, .fault_interrupt);

// ### afp_conv_model.sv
// behavioural converter answering the scheduler's start pulses
`timescale 1ns/100ps
module afp_conv_model
  import afp_pkg::*;
(
  input  wire logic            core_clk,  // system clock
  input  wire logic            rst,       // reset
  input  wire afp_conv_s       conv_ctl,  // select and start
  input  wire logic            slow,      // long conversion
  input  wire logic [7:0][9:0] lvl,       // level per channel
  output logic                 conv_done, // result strobe
  output logic      [9:0]      conv_data  // result
);
  logic [4:0] cnt_reg;
  logic [2:0] sel_reg;
  logic [9:0] last_reg;
  // data is scrambled outside the strobe so a late capture shows
  assign conv_data = conv_done ? lvl[sel_reg] : ~last_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      sel_reg <= 3'h0;
      last_reg <= 10'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_ctl.start) begin
        cnt_reg <= slow ? 5'h14 : 5'h03;
        sel_reg <= conv_ctl.sel;
      end else if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
        conv_done <= (cnt_reg == 5'h01);
      end
      if (conv_done) begin
        last_reg <= lvl[sel_reg];
      end
    end
  end
endmodule

// ### afp_core_test.sv
// self-checking bench for the conversion scheduler and fault guard
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module afp_core_test;
  import afp_pkg::*;
  logic            core_clk, rst, sfr_wr, sfr_rd, carrier_peak, carrier_valley;
  logic            timer0_ovf, pwm_cycle_start, hall_period_ovf, conv_done, slow;
  logic            pwm_enable, adc_ready_irq, fault_interrupt;
  logic [7:0]      sfr_addr, sfr_wdata, sfr_rdata, q, ci;
  logic [2:0]      hall_state, current_sense_en;
  logic [9:0]      conv_data;
  logic [7:0][9:0] lvl;
  afp_conv_s       conv_ctl;
  int              n_errors, total_checks, n_conv;
  logic [7:0]      ridx [6] = '{8'h1F, 8'h2E, 8'h44, 8'h45, 8'h46, 8'h50};
  logic [7:0]      rval [6] = '{8'h00, 8'h07, 8'hFF, 8'h00, 8'hFF, 8'h00};
  int              nexp [5] = '{8, 3, 3, 3, 6};
  afp_core afp_core_i (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .carrier_peak, .carrier_valley, .timer0_ovf, .pwm_cycle_start, .hall_state,
    .hall_period_ovf, .conv_ctl, .conv_done, .conv_data, .current_sense_en, .pwm_enable,
    .adc_ready_irq, .fault_interrupt);
  afp_conv_model afp_conv_model_i (.core_clk, .rst, .conv_ctl, .slow, .lvl, .conv_done,
    .conv_data);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (conv_ctl.start) n_conv++;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = wr;
    sfr_rd = !wr;
    cyc(1);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    cyc(1);
  endtask
  task automatic mr_wr(input logic [7:0] i, input logic [7:0] d);
    sfr(1'b1, AFP_SFR_INDEX, i);
    sfr(1'b1, AFP_SFR_WINDOW, d);
  endtask
  task automatic mr_rd(input logic [7:0] i);
    sfr(1'b1, AFP_SFR_INDEX, i);
    sfr(1'b0, AFP_SFR_WINDOW, 8'h00);
    q = sfr_rdata;
  endtask
  task automatic pulse(input int src);
    case (src)
      0: carrier_peak = 1'b1;
      1: carrier_valley = 1'b1;
      2: timer0_ovf = 1'b1;
      default: sfr(1'b1, AFP_SFR_WINDOW, 8'h13);
    endcase
    cyc(1);
    carrier_peak = 1'b0;
    carrier_valley = 1'b0;
    timer0_ovf = 1'b0;
  endtask
  task automatic trig(input int src, input int exp);
    int k;
    mr_wr(AFP_MR_ADC_CFG, 8'(src) | 8'h0C);
    `CHK("gain", 2'h3, conv_ctl.gain)
    pulse(src == 0 ? 1 : 0);
    cyc(3);
    `CHK("unselected", 1'b0, conv_ctl.hold)
    n_conv = 0;
    pulse(src);
    mr_rd(AFP_MR_ADC_CFG);
    `CHK("busy", 1'b1, q[5])
    pulse(src);
    for (k = 0; k < 3000 && adc_ready_irq !== 1'b1; k++) cyc(1);
    `CHK("ready", 1'b1, adc_ready_irq)
    `CHK("channels", exp, n_conv)
  endtask
  task automatic pwm_cycle();
    pwm_cycle_start = 1'b1;
    cyc(1);
    pwm_cycle_start = 1'b0;
  endtask
  initial begin
    {sfr_wr, sfr_rd, carrier_peak, carrier_valley, timer0_ovf} = 5'h00;
    {pwm_cycle_start, hall_period_ovf, slow} = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    hall_state = 3'h5;
    for (int i = 0; i < 8; i++) lvl[i] = 10'h2A5 - 10'(i * 37);
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cyc(1);
    `CHK("sense", 3'h7, current_sense_en)
    foreach (ridx[i]) begin
      mr_rd(ridx[i]);
      `CHK("reset value", rval[i], q)
    end
    mr_wr(AFP_MR_IN_CFG, 8'h05);
    `CHK("sense", 3'h5, current_sense_en)
    sfr(1'b0, AFP_SFR_INDEX, 8'h00);
    sfr(1'b0, 8'h80, 8'h00);
    `CHK("index", AFP_MR_IN_CFG, sfr_rdata)
    for (int t = 0; t < 5; t++) begin
      slow = t[0];
      trig(t % 4, nexp[t]);
    end
    for (int ch = 0; ch < 8; ch++) begin
      ci = (ch < 3) ? 8'(8'h20 + 2 * ch) : (ch < 6) ? 8'(8'h22 + 2 * ch) :
           (ch == 6) ? AFP_MR_AUX0_LO : AFP_MR_AUX3_LO;
      mr_rd(ci);
      `CHK("result low", lvl[ch][7:0], q)
      mr_rd(ci + 8'h01);
      `CHK("result high", {6'h00, lvl[ch][9:8]}, q)
    end
    mr_wr(AFP_MR_CUR_FIRST, 8'h00);
    mr_rd(AFP_MR_CUR_FIRST);
    `CHK("read only", lvl[0][7:0], q)
    for (int h = 0; h < 8; h += 7) begin
      hall_state = 3'(h);
      cyc(2);
      `CHK("hall pwm", 1'b0, pwm_enable)
      `CHK("hall irq", 1'b1, fault_interrupt)
      pwm_cycle();
      `CHK("hall hold", 1'b0, pwm_enable)
      hall_state = 3'h5;
      mr_rd(AFP_MR_FAULT);
      `CHK("hall status", 8'h90, q)
      mr_wr(AFP_MR_FAULT, 8'h10);
      `CHK("hall resume", 1'b1, pwm_enable)
      `CHK("hall clear", 1'b0, fault_interrupt)
    end
    hall_period_ovf = 1'b1;
    cyc(1);
    hall_period_ovf = 1'b0;
    cyc(2);
    `CHK("slow irq", 1'b1, fault_interrupt)
    `CHK("slow pwm", 1'b1, pwm_enable)
    mr_wr(AFP_MR_FAULT, 8'h08);
    `CHK("slow clear", 1'b0, fault_interrupt)
    mr_wr(AFP_MR_POS_LIM, 8'h80);
    mr_wr(AFP_MR_NEG_LIM, 8'h10);
    mr_wr(AFP_MR_SHORT_LIM, 8'hC0);
    lvl[0] = 10'h3FC;
    lvl[1] = 10'h004;
    lvl[2] = 10'h100;
    trig(0, 3);
    `CHK("limit pwm", 1'b0, pwm_enable)
    mr_rd(AFP_MR_FAULT);
    `CHK("limit status", 8'hE1, q)
    `CHK("short irq", 1'b1, fault_interrupt)
    pwm_cycle();
    `CHK("cycle resume", 1'b1, pwm_enable)
    `CHK("short sticky", 1'b1, fault_interrupt)
    mr_wr(AFP_MR_FAULT, 8'h7F);
    `CHK("software clear", 1'b0, fault_interrupt)
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule
